//--- design/agsd_decoder.sv
// Notes on behaviour
// (R01) arbiter signals permitted action via status
// (R02) decode status only while grant asserted
// (R03) ignore status while grant deasserted
// (R04) code 000: accept low priority read data
// (R05) code 001: accept high priority read data
// (R06) code 010: drive low priority write data
// (R07) code 011: drive high priority write data
// (R08) reserved codes: no data, no transaction
// (R09) code 111: may start a transaction
// (R10) status bus is input only, never driven
// (R11) arbiter withholds low reads while buffer full
// (R12) pipelined request enqueues one read per edge
`timescale 1ns/1ps
`default_nettype none
module agsd_decoder (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // arbiter pins, input only
  input  wire logic       busGrantN,
  input  wire logic [2:0] grantStatusCode,
  // local flow control from the master logic
  input  wire logic       readBufferFull,
  input  wire logic       pipeRequest,
  // decoded permissions, one cycle per granted clock
  output logic            acceptReadLo,
  output logic            acceptReadHi,
  output logic            driveWriteLo,
  output logic            driveWriteHi,
  output logic            startAllowed,
  output logic            reservedSeen,
  // pins toward the arbiter
  output logic            read_buffer_full_n,
  output logic            pipelined_request_n
);
  agsd_if syncBus ();

  // ports and codes are fixed at three status bits
  if (agsd_pkg::STATUS_W != 3) begin : g_widthCheck
    $error("status bus must be three bits wide");
  end

  // pins enter through two flops, costing two cycles of latency
  agsd_sampler u_sampler (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .busGrantN       (busGrantN),
    .grantStatusCode (grantStatusCode),
    .syncBus         (syncBus)
  );

  agsd_pkg::agsd_grant_t grantNext;
  logic [7:0]            outReg;
  logic [7:0]            outNext;
  logic                  pipeActiveReg;
  logic                  pipeActiveNext;

  function automatic agsd_pkg::agsd_grant_t decodeCode(input logic valid,
                                                      input logic [2:0] code);
    agsd_pkg::agsd_grant_t g;
    g = agsd_pkg::AGSD_IDLE;
    if (valid) begin
      unique case (code)
        agsd_pkg::CODE_READ_LO:  g = agsd_pkg::AGSD_READ_LO;
        agsd_pkg::CODE_READ_HI:  g = agsd_pkg::AGSD_READ_HI;
        agsd_pkg::CODE_WRITE_LO: g = agsd_pkg::AGSD_WRITE_LO;
        agsd_pkg::CODE_WRITE_HI: g = agsd_pkg::AGSD_WRITE_HI;
        agsd_pkg::CODE_START:    g = agsd_pkg::AGSD_START;
        default:                 g = agsd_pkg::AGSD_RESERVED;
      endcase
    end
    return g;
  endfunction

  always_comb begin
    // (R02) decode when granted
    // (R03) ignore when not granted
    grantNext = decodeCode(syncBus.grantValid, syncBus.statusCode);
    outNext = 8'h00;
    unique case (grantNext)
      // (R04) low read accept
      agsd_pkg::AGSD_READ_LO:  outNext[0] = 1'b1;
      // (R05) high read accept
      agsd_pkg::AGSD_READ_HI:  outNext[1] = 1'b1;
      // (R06) low write drive
      agsd_pkg::AGSD_WRITE_LO: outNext[2] = 1'b1;
      // (R07) high write drive
      agsd_pkg::AGSD_WRITE_HI: outNext[3] = 1'b1;
      // (R09) start permitted
      agsd_pkg::AGSD_START:    outNext[4] = 1'b1;
      // (R08) reserved only flags reservedSeen
      agsd_pkg::AGSD_RESERVED: outNext[5] = 1'b1;
      agsd_pkg::AGSD_IDLE:     outNext = 8'h00;
    endcase
    // (R11) advertise buffer full
    outNext[6] = ~readBufferFull;
    // (R12) request only while master
    pipeActiveNext = pipeRequest & (pipeActiveReg | (grantNext == agsd_pkg::AGSD_START));
    outNext[7] = ~pipeActiveNext;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // reset leaves both pins toward the arbiter deasserted
      outReg        <= agsd_pkg::OUT_RESET;
      pipeActiveReg <= 1'b0;
    end else begin
      outReg        <= outNext;
      pipeActiveReg <= pipeActiveNext;
    end
  end

  // (R10) status only received
  assign acceptReadLo        = outReg[0];
  assign acceptReadHi        = outReg[1];
  assign driveWriteLo        = outReg[2];
  assign driveWriteHi        = outReg[3];
  assign startAllowed        = outReg[4];
  assign reservedSeen        = outReg[5];
  assign read_buffer_full_n  = outReg[6];
  assign pipelined_request_n = outReg[7];

  property p_noGrantNoAction; // (R03)
    @(posedge clk_sys) disable iff (!rstn)
      !syncBus.grantValid |=> (outReg[5:0] == 6'h00);
  endproperty
  a_noGrantNoAction: assert property (p_noGrantNoAction) else $error("action without grant"); // (R03)

  property p_readLo; // (R04)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && syncBus.statusCode == 3'h0 |=> acceptReadLo && !acceptReadHi;
  endproperty
  a_readLo: assert property (p_readLo) else $error("low read not accepted"); // (R04)

  property p_readHi; // (R05)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && syncBus.statusCode == 3'h1 |=> acceptReadHi;
  endproperty
  a_readHi: assert property (p_readHi) else $error("high read not accepted"); // (R05)

  property p_writeLo; // (R06)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && syncBus.statusCode == 3'h2 |=> driveWriteLo && !driveWriteHi;
  endproperty
  a_writeLo: assert property (p_writeLo) else $error("low write not driven"); // (R06)

  property p_writeHi; // (R07)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && syncBus.statusCode == 3'h3 |=> driveWriteHi;
  endproperty
  a_writeHi: assert property (p_writeHi) else $error("high write not driven"); // (R07)

  property p_reserved; // (R08)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && (syncBus.statusCode inside {3'h4, 3'h5, 3'h6})
        |=> reservedSeen && (outReg[4:0] == 5'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted"); // (R08)

  property p_start; // (R09)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && syncBus.statusCode == 3'h7 |=> startAllowed;
  endproperty
  a_start: assert property (p_start) else $error("start not permitted"); // (R09)

  property p_grantDecoded; // (R02)
    @(posedge clk_sys) disable iff (!rstn)
      $rose(busGrantN == 1'b0) |-> ##3 (outReg[5:0] != 6'h00) || busGrantN;
  endproperty
  a_grantDecoded: assert property (p_grantDecoded) else $error("grant not decoded"); // (R02)

  property p_pipe; // (R12)
    @(posedge clk_sys) disable iff (!rstn)
      !pipeRequest |=> pipelined_request_n;
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipe request without cause"); // (R12)

  property p_rbf; // (R11)
    @(posedge clk_sys) disable iff (!rstn)
      readBufferFull |=> !read_buffer_full_n;
  endproperty
  a_rbf: assert property (p_rbf) else $error("buffer full not shown"); // (R11)

  property p_rbfClear; // (R11)
    @(posedge clk_sys) disable iff (!rstn)
      !readBufferFull |=> read_buffer_full_n;
  endproperty
  a_rbfClear: assert property (p_rbfClear) else $error("buffer full shown wrongly"); // (R11)

  property p_grantIdle; // (R03)
    @(posedge clk_sys) disable iff (!rstn)
      busGrantN |-> ##3 (outReg[5:0] == 6'h00);
  endproperty
  a_grantIdle: assert property (p_grantIdle) else $error("action while grant idle"); // (R03)

  property p_codeHeld; // (R02)
    @(posedge clk_sys) disable iff (!rstn)
      syncBus.grantValid && $past(syncBus.grantValid) && $stable(syncBus.statusCode)
        |=> $stable(outReg[5:0]);
  endproperty
  a_codeHeld: assert property (p_codeHeld) else $error("held code changed action"); // (R02)

  property p_pipeStart; // (R12)
    @(posedge clk_sys) disable iff (!rstn)
      $fell(pipelined_request_n) |-> startAllowed;
  endproperty
  a_pipeStart: assert property (p_pipeStart) else $error("pipe opened without start"); // (R12)

  property p_pipeHold; // (R12)
    @(posedge clk_sys) disable iff (!rstn)
      pipeRequest && !pipelined_request_n |=> !pipelined_request_n;
  endproperty
  a_pipeHold: assert property (p_pipeHold) else $error("pipe dropped while requested"); // (R12)

  property p_startPipe; // (R09)
    @(posedge clk_sys) disable iff (!rstn)
      pipeRequest && syncBus.grantValid && syncBus.statusCode == 3'h7
        |=> !pipelined_request_n;
  endproperty
  a_startPipe: assert property (p_startPipe) else $error("start did not open pipe"); // (R09)

  property p_reservedNoPipe; // (R08)
    @(posedge clk_sys) disable iff (!rstn)
      reservedSeen && $past(pipelined_request_n) |-> pipelined_request_n;
  endproperty
  a_reservedNoPipe: assert property (p_reservedNoPipe) else $error("reserved opened pipe"); // (R08)
endmodule
`default_nettype wire

//--- design/agsd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface agsd_if;
  logic                      grantValid;
  logic [2:0]                statusCode;
  modport decoder (input grantValid, input statusCode);
  modport sampler (output grantValid, output statusCode);
endinterface
`default_nettype wire

//--- design/agsd_pkg.sv
package agsd_pkg;
  localparam int  STATUS_W          = 3;
  localparam logic [2:0] CODE_READ_LO  = 3'h0;
  localparam logic [2:0] CODE_READ_HI  = 3'h1;
  localparam logic [2:0] CODE_WRITE_LO = 3'h2;
  localparam logic [2:0] CODE_WRITE_HI = 3'h3;
  localparam logic [2:0] CODE_START    = 3'h7;
  localparam int  SYNC_STAGES       = 2;
  localparam logic [3:0] SYNC_RESET    = 4'h0;
  localparam logic [7:0] OUT_RESET     = 8'hC0;

  typedef enum logic [2:0] {
    AGSD_IDLE,
    AGSD_READ_LO,
    AGSD_READ_HI,
    AGSD_WRITE_LO,
    AGSD_WRITE_HI,
    AGSD_START,
    AGSD_RESERVED
  } agsd_grant_t;
endpackage

//--- design/agsd_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module agsd_sampler (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // pins from the arbiter
  input  wire logic       busGrantN,
  input  wire logic [2:0] grantStatusCode,
  // synchronised view
  agsd_if.sampler         syncBus
);
  logic [3:0] stage1Reg;
  logic [3:0] stage1Next;
  logic [3:0] stage2Reg;
  logic [3:0] stage2Next;

  // the chain below is written for exactly two stages
  if (agsd_pkg::SYNC_STAGES != 2) begin : g_stageCheck
    $error("sampler supports two synchroniser stages only");
  end

  always_comb begin
    stage1Next = {~busGrantN, grantStatusCode};
    stage2Next = stage1Reg;
  end

  // first stage is read only by the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1Reg <= agsd_pkg::SYNC_RESET;
      stage2Reg <= agsd_pkg::SYNC_RESET;
    end else begin
      stage1Reg <= stage1Next;
      stage2Reg <= stage2Next;
    end
  end

  assign syncBus.grantValid = stage2Reg[3];
  assign syncBus.statusCode = stage2Reg[2:0];
endmodule
`default_nettype wire

//--- test/agsd_arbiter_model.sv
`timescale 1ns/1ps
`default_nettype none
module agsd_arbiter_model (
  // clock
  input  wire logic       clk_sys,
  // requests from the bench
  input  wire logic       wantGrant,
  input  wire logic [2:0] wantCode,
  // device pins
  input  wire logic       read_buffer_full_n,
  output logic            busGrantN,
  output logic [2:0]      grantStatusCode
);
  logic       g;
  logic [2:0] c;
  initial begin
    busGrantN = 1'b1;
    grantStatusCode = 3'h0;
  end
  always @(posedge clk_sys) begin
    g = wantGrant;
    c = wantCode;
    #1;
    if (g && !(c == 3'h0 && !read_buffer_full_n)) begin
      busGrantN = 1'b0;
      grantStatusCode = c;
    end else begin
      busGrantN = 1'b1;
      // idle status is garbage, kept moving so no stale value passes
      grantStatusCode = ~grantStatusCode;
    end
  end
endmodule
`default_nettype wire

//--- test/agsd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module agsd_decoder_tb;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED at %0t: output mismatch", $time); end end
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        wantGrant = 1'b0;
  logic [2:0]  wantCode = 3'h0;
  logic        readBufferFull = 1'b0;
  logic        pipeRequest = 1'b0;
  logic        busGrantN;
  logic [2:0]  grantStatusCode;
  wire  [5:0]  decOut;
  wire         rbfN;
  wire         pipeN;
  int          n_fail = 0;
  int          num_checks = 0;
  int          hist[$];
  int          e;
  logic [5:0]  d;
  logic        pipeExp;
  logic        rbfExp;
  logic [31:0] r;
  logic [31:0] rng = 32'h0000_000b;

  always #12.5 clk_sys = ~clk_sys;

  agsd_arbiter_model i_arb (.clk_sys(clk_sys), .wantGrant(wantGrant), .wantCode(wantCode),
    .read_buffer_full_n(rbfN), .busGrantN(busGrantN), .grantStatusCode(grantStatusCode));
  agsd_decoder i_dut (.clk_sys(clk_sys), .rstn(rstn), .busGrantN(busGrantN),
    .grantStatusCode(grantStatusCode), .readBufferFull(readBufferFull),
    .pipeRequest(pipeRequest), .acceptReadLo(decOut[5]), .acceptReadHi(decOut[4]),
    .driveWriteLo(decOut[3]), .driveWriteHi(decOut[2]), .startAllowed(decOut[1]),
    .reservedSeen(decOut[0]), .read_buffer_full_n(rbfN), .pipelined_request_n(pipeN));

  function logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function logic [5:0] expDec(int v);
    return v < 0 ? 6'h00 : v == 7 ? 6'h02 : v > 3 ? 6'h01 : 6'h20 >> v;
  endfunction

  // reference: two sync stages then an output register
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hist = '{-1, -1};
      pipeExp = 1'b1;
    end else begin
      hist.push_back(busGrantN ? -1 : int'(grantStatusCode));
      e = hist.pop_front();
      d = expDec(e);
      pipeExp = !(pipeRequest && (d[1] || !pipeExp));
      // the input moves 1 ns after this edge, so keep what was sampled
      rbfExp = !readBufferFull;
      #5;
      if (rstn) begin
        `CHK(decOut, d)
        `CHK(pipeN, pipeExp)
        `CHK(rbfN, rbfExp)
      end
    end
  end

  task drive(input logic g, input logic [2:0] c, input logic f, input logic p);
    @(posedge clk_sys);
    #1;
    wantGrant = g;
    wantCode = c;
    readBufferFull = f;
    pipeRequest = p;
  endtask

  task complete_run();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(25 * 3000);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    for (int c = 0; c < 8; c++) drive(1'b1, 3'(c), 1'b0, 1'b0);
    repeat (5) drive(1'b0, 3'h0, 1'b0, 1'b0);
    $display("test all codes done");
    for (int i = 0; i < 600; i++) begin
      r = nxt();
      drive(r[0] | r[1], r[4:2], r[5] & i[8], r[5] | i[7]);
    end
    $display("test random traffic done");
    repeat (3) drive(1'b1, 3'h7, 1'b1, 1'b1);
    // reset lands with the stimulus, 1 ns after the edge
    rstn = 1'b0;
    #2;
    `CHK({decOut, rbfN, pipeN}, 8'h03)
    drive(1'b1, 3'h7, 1'b0, 1'b1);
    rstn = 1'b1;
    repeat (8) drive(1'b1, 3'h7, 1'b0, 1'b1);
    repeat (4) drive(1'b0, 3'h0, 1'b0, 1'b0);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
`default_nettype wire
